// ### logic/ppe_pkg.sv
package ppe_pkg;
  // Register offsets within each window
  localparam logic [2:0] OFS1_DATA = 3'h0;
  localparam logic [2:0] OFS1_STAT = 3'h1;
  localparam logic [2:0] OFS1_CTRL = 3'h2;
  localparam logic [2:0] OFS1_EPP_FIRST = 3'h4;
  localparam logic [1:0] OFS2_FIFO = 2'h0;
  localparam logic [1:0] OFS2_CAPB = 2'h1;
  localparam logic [1:0] OFS2_ECR = 2'h2;
  localparam logic [15:0] WIN1_SPAN = 16'h0008;
  localparam logic [15:0] WIN2_SPAN = 16'h0003;
  // Port modes held in the extended control register
  localparam logic [2:0] MODE_STD = 3'h0;
  localparam logic [2:0] MODE_PS2 = 3'h1;
  localparam logic [2:0] MODE_COMPAT_DATA_FIFO = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CONFIG = 3'h7;
  // Field positions
  localparam int DCR_DIR_BIT = 5;
  localparam int DCR_SELIN_BIT = 3;
  localparam int DCR_INIT_BIT = 2;
  localparam int DCR_AUTOFD_BIT = 1;
  localparam int DCR_STROBE_BIT = 0;
  localparam int ECR_FERR_DIS_BIT = 2;
  localparam int RLE_FLAG_BIT = 7;
  // Reset and fixed values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [5:0] DCR_RST = 6'h00;
  localparam logic [2:0] ECR_MODE_RST = 3'h0;
  localparam logic [2:0] ECR_CTL_RST = 3'h1;
  localparam logic [1:0] DCR_HIGH_BITS = 2'h3;
  localparam logic [2:0] DSR_LOW_ONES = 3'h7;
  localparam logic [7:0] CAP_A_VAL = 8'h10;
  localparam logic [7:0] CAP_B_VAL = 8'h00;
  localparam logic [7:0] UNMAPPED_VAL = 8'hff;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {EPP_IDLE, EPP_STB, EPP_END} ppe_epp_t;
  typedef enum logic [1:0] {FWD_IDLE, FWD_SETUP, FWD_STB, FWD_REL} ppe_fwd_t;
  typedef enum logic [1:0] {REV_IDLE, REV_REQ, REV_ACK, REV_PUSH} ppe_rev_t;
endpackage : ppe_pkg

// ### logic/ppe_port.sv
`timescale 1ns/1ps
// Functional notes
// - Enhanced data read releases the data lines in the same cycle as strobing.
// - Enhanced data read drives the data strobe low once the read starts.
// - On wait released, strobe rises and the bus byte is captured and returned.
// - Sixteen-byte FIFO serves forward and reverse traffic.
// - Run-length bytes from the peripheral are expanded; no outgoing compression.
// - FIFO standard mode sends bytes with automatic strobe/busy handshake.
// - Forward and reverse automatic transfers are both supported.
// - Window one base from config bytes 60h/61h, window two from 62h/63h.
// - Three-bit mode selects standard, PS/2, FIFO, extended, test or config.
// - Plain data register at window one offset 0 only in modes 000/001.
// - Forward: host clock strobe and busy handshake each byte.
// - Reverse: peripheral clock and host acknowledge handshake each byte.
// - Host ack requests reverse bytes, marks command/data going forward.
// - Fault low during forward extended mode requests a reverse transfer.
// - Reverse request pin low turns the bus; peripheral drives then and during enhanced data reads.
// - Select-in output held high in extended mode.
// - Data register clears on reset; writes drive lines uninverted.
// - Reading the data register returns data port contents.
// - Capability A reads fixed 10h.
// - Status register low three bits read as one.
// - Extended control bits 7..5 hold the read/write mode.

module ppe_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Sync reset
  input wire logic flush, // Empty the buffer
  input wire logic in_valid, // Push request
  output logic in_ready, // Space available
  input wire logic [WIDTH-1:0] in_data, // Pushed word
  output logic out_valid, // Word available
  input wire logic out_ready, // Pop request
  output logic [WIDTH-1:0] out_data, // Head word
  output logic full, // No space
  output logic empty // No words
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) $error("ppe_fifo: bad geometry");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r, rd_ptr_r;
  logic push, pop;
  assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty = wr_ptr_r == rd_ptr_r;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;
  assign out_data = mem[rd_ptr_r[AW-1:0]];
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset || flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule : ppe_fifo

module ppe_port import ppe_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_sys, // System clock, 20 MHz
  input wire logic reset, // Sync reset, active high
  input wire logic [7:0] cfg_base1_hi, // Config byte 60h
  input wire logic [7:0] cfg_base1_lo, // Config byte 61h
  input wire logic [7:0] cfg_base2_hi, // Config byte 62h
  input wire logic [7:0] cfg_base2_lo, // Config byte 63h
  input wire logic epp_enable, // Enhanced ports decoded
  input wire logic [15:0] io_addr, // Host I/O address
  input wire logic io_wr, // Host write pulse
  input wire logic [7:0] io_wdata, // Host write data
  input wire logic io_rd, // Host read pulse
  output logic [7:0] io_rdata, // Read data
  output logic io_rdy, // Read answer pulse
  input wire logic [7:0] parallel_data_lines_in, // Data lines in
  output logic [7:0] parallel_data_lines_out, // Data lines out
  output logic parallel_data_lines_oe, // Data lines drive enable
  output logic host_clock_out_n, // Strobe pin
  output logic host_ack_out_n, // Auto-feed pin
  output logic data_strobe_n, // Enhanced data strobe
  output logic reverse_request_out_n, // Init pin
  output logic select_in_out_n, // Select-in pin
  input wire logic periph_flow_ack, // Busy pin
  input wire logic periph_clock_in_n, // Ack pin
  input wire logic reverse_ack_n, // Paper-error pin
  input wire logic select_in, // Select pin
  input wire logic fault_in_n, // Fault pin
  output logic periph_request // Reverse request event pulse
);
  initial begin
    if (DEPTH != FIFO_DEPTH) $error("ppe_port: FIFO must hold 16 bytes");
  end

  function automatic logic in_win(input logic [15:0] a, input logic [15:0] b, input logic [15:0] span);
    logic [15:0] d;
    d = a - b;
    return (a >= b) && (d < span);
  endfunction : in_win

  logic [15:0] base1, base2, off1, off2;
  logic hit1, hit2;
  assign base1 = {cfg_base1_hi, cfg_base1_lo};
  assign base2 = {cfg_base2_hi, cfg_base2_lo};
  assign hit1 = in_win(io_addr, base1, WIN1_SPAN);
  assign hit2 = in_win(io_addr, base2, WIN2_SPAN);
  assign off1 = io_addr - base1;
  assign off2 = io_addr - base2;

  logic [7:0] data_r;
  logic [5:0] dcr_r;
  logic [2:0] mode_r, ecr_ctl_r;
  logic [7:0] last_r, fwd_data_r, rev_data_r, rle_cnt_r;
  logic fwd_cmd_r, rev_cmd_r, fault_d_r;
  ppe_epp_t epp_r;
  ppe_fwd_t fwd_r;
  ppe_rev_t rev_r;

  logic mode_plain, mode_fifo_out, dir_in, fwd_on, rev_on;
  assign mode_plain = (mode_r == MODE_STD) || (mode_r == MODE_PS2);
  assign mode_fifo_out = (mode_r == MODE_COMPAT_DATA_FIFO) || (mode_r == MODE_ECP);
  assign dir_in = (mode_r == MODE_STD || mode_r == MODE_COMPAT_DATA_FIFO) ? 1'b0 : dcr_r[DCR_DIR_BIT];
  assign fwd_on = mode_fifo_out && !dir_in;
  assign rev_on = (mode_r == MODE_ECP) && dir_in;

  logic wr1_data, wr1_ctrl, wr2_fifo, wr2_ecr, rd1_epp, rd2_fifo, addr_fifo_wr;
  assign wr1_data = io_wr && hit1 && off1[2:0] == OFS1_DATA && mode_plain;
  assign addr_fifo_wr = io_wr && hit1 && off1[2:0] == OFS1_DATA && mode_r == MODE_ECP && !dir_in;
  assign wr1_ctrl = io_wr && hit1 && off1[2:0] == OFS1_CTRL;
  assign wr2_fifo = io_wr && hit2 && off2[1:0] == OFS2_FIFO && (fwd_on || mode_r == MODE_TEST);
  assign wr2_ecr = io_wr && hit2 && off2[1:0] == OFS2_ECR;
  assign rd1_epp = io_rd && hit1 && off1[2:0] >= OFS1_EPP_FIRST && epp_enable && mode_plain;
  assign rd2_fifo = io_rd && hit2 && off2[1:0] == OFS2_FIFO && (rev_on || mode_r == MODE_TEST);

  // Shared buffer, tagged with a command bit
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_full, f_empty, f_flush;
  logic [8:0] f_in_data, f_out_data;
  assign f_flush = mode_r == MODE_STD;
  always_comb begin
    f_in_valid = 1'b0;
    f_in_data = {1'b0, io_wdata};
    if (rev_r == REV_PUSH) begin
      f_in_valid = 1'b1;
      f_in_data = {1'b0, rev_data_r};
    end else if (addr_fifo_wr) begin
      f_in_valid = 1'b1;
      f_in_data = {1'b1, io_wdata};
    end else if (wr2_fifo) begin
      f_in_valid = 1'b1;
    end
  end
  assign f_out_ready = (fwd_r == FWD_IDLE && fwd_on) || rd2_fifo;

  ppe_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .flush(f_flush),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data),
    .full(f_full),
    .empty(f_empty)
  );

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      data_r <= DATA_RST;
    end else if (wr1_data) begin
      data_r <= io_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dcr_r <= DCR_RST;
    end else if (wr1_ctrl) begin
      dcr_r <= io_wdata[5:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_r <= ECR_MODE_RST;
      ecr_ctl_r <= ECR_CTL_RST;
    end else if (wr2_ecr) begin
      mode_r <= io_wdata[7:5];
      ecr_ctl_r <= io_wdata[4:2];
    end
  end

  // Last byte popped, returned when test FIFO is read empty
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      last_r <= DATA_RST;
    end else if (f_out_ready && f_out_valid) begin
      last_r <= f_out_data[7:0];
    end
  end

  // Enhanced data read handshake
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      epp_r <= EPP_IDLE;
    end else begin
      case (epp_r)
        EPP_IDLE: begin
          if (rd1_epp) begin
            epp_r <= EPP_STB;
          end
        end
        EPP_STB: begin
          if (periph_flow_ack) begin
            epp_r <= EPP_END;
          end
        end
        EPP_END: begin
          if (!periph_flow_ack) begin
            epp_r <= EPP_IDLE;
          end
        end
        default: epp_r <= EPP_IDLE;
      endcase
    end
  end

  // Forward engine: buffer to peripheral
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fwd_r <= FWD_IDLE;
      fwd_data_r <= DATA_RST;
      fwd_cmd_r <= 1'b0;
    end else begin
      case (fwd_r)
        FWD_IDLE: begin
          if (fwd_on && f_out_valid) begin
            fwd_data_r <= f_out_data[7:0];
            fwd_cmd_r <= f_out_data[8];
            fwd_r <= FWD_SETUP;
          end
        end
        FWD_SETUP: begin
          if (!periph_flow_ack) begin
            fwd_r <= FWD_STB;
          end
        end
        FWD_STB: begin
          if (periph_flow_ack) begin
            fwd_r <= FWD_REL;
          end
        end
        FWD_REL: begin
          if (!periph_flow_ack) begin
            fwd_r <= FWD_IDLE;
          end
        end
        default: fwd_r <= FWD_IDLE;
      endcase
    end
  end

  // Reverse engine: peripheral to buffer, with run-length expansion
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rev_r <= REV_IDLE;
      rev_data_r <= DATA_RST;
      rev_cmd_r <= 1'b0;
      rle_cnt_r <= DATA_RST;
    end else begin
      case (rev_r)
        REV_IDLE: begin
          if (rev_on && f_in_ready) begin
            rev_r <= REV_REQ;
          end
        end
        REV_REQ: begin
          if (!periph_clock_in_n) begin
            rev_data_r <= parallel_data_lines_in;
            rev_cmd_r <= !periph_flow_ack;
            rev_r <= REV_ACK;
          end
        end
        REV_ACK: begin
          if (periph_clock_in_n) begin
            if (!rev_cmd_r) begin
              rev_r <= REV_PUSH;
            end else begin
              if (!rev_data_r[RLE_FLAG_BIT]) begin
                rle_cnt_r <= rev_data_r;
              end
              rev_r <= REV_IDLE;
            end
          end
        end
        REV_PUSH: begin
          if (f_in_ready) begin
            if (rle_cnt_r == 8'h00) begin
              rev_r <= REV_IDLE;
            end else begin
              rle_cnt_r <= rle_cnt_r - 8'h01;
            end
          end
        end
        default: rev_r <= REV_IDLE;
      endcase
    end
  end

  // Peripheral request on falling fault, forward extended mode only
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fault_d_r <= 1'b1;
      periph_request <= 1'b0;
    end else begin
      fault_d_r <= fault_in_n;
      periph_request <= fault_d_r && !fault_in_n && mode_r == MODE_ECP && !dir_in
                        && !ecr_ctl_r[ECR_FERR_DIS_BIT];
    end
  end

  // Host read answers
  logic [7:0] rd_val;
  always_comb begin
    rd_val = UNMAPPED_VAL;
    if (hit1 && off1[2:0] == OFS1_DATA) begin
      if (mode_plain) begin
        rd_val = (mode_r == MODE_PS2 && dir_in) ? parallel_data_lines_in : data_r;
      end
    end else if (hit1 && off1[2:0] == OFS1_STAT) begin
      rd_val = {!periph_flow_ack, periph_clock_in_n, reverse_ack_n, select_in, fault_in_n, DSR_LOW_ONES};
    end else if (hit1 && off1[2:0] == OFS1_CTRL) begin
      rd_val = {DCR_HIGH_BITS, dcr_r};
    end else if (hit2 && off2[1:0] == OFS2_FIFO) begin
      if (mode_r == MODE_CONFIG) begin
        rd_val = CAP_A_VAL;
      end else if (rd2_fifo) begin
        rd_val = f_empty ? last_r : f_out_data[7:0];
      end
    end else if (hit2 && off2[1:0] == OFS2_CAPB) begin
      if (mode_r == MODE_CONFIG) begin
        rd_val = CAP_B_VAL;
      end
    end else if (hit2 && off2[1:0] == OFS2_ECR) begin
      rd_val = {mode_r, ecr_ctl_r, f_full, f_empty};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      io_rdy <= 1'b0;
      io_rdata <= DATA_RST;
    end else begin
      io_rdy <= 1'b0;
      if (epp_r == EPP_STB && periph_flow_ack) begin
        io_rdy <= 1'b1;
        io_rdata <= parallel_data_lines_in;
      end else if (io_rd && !rd1_epp) begin
        io_rdy <= 1'b1;
        io_rdata <= rd_val;
      end
    end
  end

  // Pins
  always_comb begin
    parallel_data_lines_out = data_r;
    if (fwd_on) begin
      parallel_data_lines_out = fwd_data_r;
    end else if (mode_r == MODE_TEST) begin
      parallel_data_lines_out = f_empty ? last_r : f_out_data[7:0];
    end
  end
  assign parallel_data_lines_oe = !dir_in && epp_r == EPP_IDLE;
  assign data_strobe_n = epp_r != EPP_STB;
  assign host_clock_out_n = fwd_on ? fwd_r != FWD_STB : !dcr_r[DCR_STROBE_BIT];
  always_comb begin
    if (epp_r != EPP_IDLE) begin
      host_ack_out_n = data_strobe_n;
    end else if (rev_on) begin
      host_ack_out_n = rev_r != REV_REQ;
    end else if (fwd_on && mode_r == MODE_ECP) begin
      host_ack_out_n = fwd_cmd_r ? 1'b0 : 1'b1;
    end else begin
      host_ack_out_n = !dcr_r[DCR_AUTOFD_BIT];
    end
  end
  assign reverse_request_out_n = dcr_r[DCR_INIT_BIT];
  assign select_in_out_n = (mode_r == MODE_ECP) ? 1'b1 : !dcr_r[DCR_SELIN_BIT];

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_epp_start;
    rd1_epp && epp_r == EPP_IDLE;
  endsequence
  sequence s_epp_ready;
    epp_r == EPP_STB && periph_flow_ack;
  endsequence

  a_epp_bus_free: assert property (s_epp_start |=> !parallel_data_lines_oe && !data_strobe_n)
    else $error("enhanced read did not release bus and strobe");
  a_epp_strobe_held: assert property (epp_r == EPP_STB |-> !data_strobe_n && !parallel_data_lines_oe)
    else $error("data strobe not low during enhanced read");
  a_epp_capture_done: assert property (s_epp_ready |=> io_rdy && data_strobe_n
                                        && io_rdata == $past(parallel_data_lines_in))
    else $error("enhanced read did not capture byte");
  a_sel_in_idle: assert property (mode_r == MODE_ECP |-> select_in_out_n)
    else $error("select-in low in extended mode");
  a_cap_a_fixed: assert property (io_rd && hit2 && off2[1:0] == OFS2_FIFO && mode_r == MODE_CONFIG
                                  |=> io_rdy && io_rdata == 8'h10)
    else $error("capability A wrong");
  a_status_low_ones: assert property (io_rd && hit1 && off1[2:0] == OFS1_STAT |=> io_rdata[2:0] == 3'h7)
    else $error("status low bits not one");
  a_data_drive_out: assert property (wr1_data && mode_r == MODE_STD && !wr2_ecr ##1 epp_r == EPP_IDLE
                                     |-> parallel_data_lines_out == $past(io_wdata))
    else $error("data write not driven");
  a_data_ignore_mode: assert property (io_wr && hit1 && off1[2:0] == OFS1_DATA && !mode_plain
                                       |=> $stable(data_r))
    else $error("data register written in wrong mode");
  a_fwd_strobe_rel: assert property (fwd_r == FWD_STB && periph_flow_ack && fwd_on |=> host_clock_out_n)
    else $error("strobe not released on busy");
  a_rev_request_low: assert property (rev_r == REV_REQ && rev_on && epp_r == EPP_IDLE |-> !host_ack_out_n)
    else $error("host ack not requesting");
  a_mode_readback: assert property (wr2_ecr |=> mode_r == $past(io_wdata[7:5]))
    else $error("mode field not stored");
endmodule : ppe_port

// ### verif/ppe_periph.sv
`timescale 1ns/1ps
module ppe_periph #(
  parameter int DLY = 3
) (
  input wire logic clk_sys, // System clock
  input wire logic host_clock_out_n, // Strobe pin
  input wire logic host_ack_out_n, // Auto-feed pin
  input wire logic data_strobe_n, // Enhanced strobe
  input wire logic reverse_request_out_n, // Init pin
  input wire logic select_in_out_n, // Select-in pin
  input wire logic [7:0] bus_in, // Resolved data lines
  output logic [7:0] bus_drive, // Our data lines
  output logic bus_oe, // We drive the lines
  output logic periph_flow_ack, // Busy pin
  output logic periph_clock_in_n, // Ack pin
  output logic reverse_ack_n, // Paper-error pin
  input wire logic [7:0] rev_byte, // Byte to send back
  input wire logic rev_cmd, // Byte is a command
  input wire logic rev_go, // Queue one reverse byte
  output logic rev_busy, // Reverse byte pending
  output logic [7:0] fwd_byte, // Last forward byte
  output logic fwd_cmd, // Last forward byte was command
  output int fwd_count // Forward bytes taken
);
  int st;
  int cnt;
  initial begin
    st = 0;
    cnt = 0;
    bus_drive = 8'h00;
    bus_oe = 1'b0;
    periph_flow_ack = 1'b0;
    periph_clock_in_n = 1'b1;
    reverse_ack_n = 1'b1;
    rev_busy = 1'b0;
    fwd_byte = 8'h00;
    fwd_cmd = 1'b0;
    fwd_count = 0;
  end
  always @(posedge clk_sys) begin
    reverse_ack_n <= reverse_request_out_n;
    if (rev_go)
      rev_busy <= 1'b1;
    case (st)
      0: if (!data_strobe_n) begin
        cnt <= 0;
        st <= 1;
      end else if (!host_clock_out_n && !periph_flow_ack) begin
        fwd_byte <= bus_in;
        fwd_cmd <= ~host_ack_out_n;
        fwd_count <= fwd_count + 1;
        periph_flow_ack <= 1'b1;
        st <= 4;
      end else if (rev_busy && !host_ack_out_n && !reverse_request_out_n && select_in_out_n) begin
        bus_oe <= 1'b1;
        bus_drive <= rev_byte;
        periph_flow_ack <= ~rev_cmd;
        periph_clock_in_n <= 1'b0;
        st <= 5;
      end
      1: if (cnt == DLY) begin
        bus_oe <= 1'b1;
        bus_drive <= rev_byte;
        periph_flow_ack <= 1'b1;
        st <= 2;
      end else
        cnt <= cnt + 1;
      2: if (data_strobe_n) begin
        bus_oe <= 1'b0;
        bus_drive <= ~bus_drive;
        st <= 3;
      end
      3: begin
        periph_flow_ack <= 1'b0;
        st <= 0;
      end
      4: if (host_clock_out_n) begin
        periph_flow_ack <= 1'b0;
        st <= 0;
      end
      5: if (host_ack_out_n) begin
        periph_clock_in_n <= 1'b1;
        bus_oe <= 1'b0;
        bus_drive <= ~bus_drive;
        periph_flow_ack <= 1'b0;
        rev_busy <= 1'b0;
        st <= 0;
      end
      default: st <= 0;
    endcase
  end
endmodule : ppe_periph

// ### verif/ppe_port_tb.sv
`timescale 1ns/1ps
module ppe_port_tb import ppe_pkg::*;;
  localparam logic [15:0] B1 = 16'h0378;
  localparam logic [15:0] B2 = 16'h06f0;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic epp_enable = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata, lines, d_out, p_drive, rev_byte = 8'h00, fwd_byte;
  logic io_rdy, d_oe, p_oe, stb_n, ack_out_n, data_strobe_n_n, init_n, selin_n, busy, pclk_n, pe_n, preq, fwd_cmd;
  logic select_in = 1'b0;
  logic [7:0] base2_lo = 8'hf0;
  logic fault_in_n = 1'b1;
  logic rev_cmd = 1'b0;
  logic rev_go = 1'b0;
  logic rev_busy;
  int fwd_count;
  int err_total = 0;
  int total_checks = 0;
  logic [2:0] modes [6] = '{MODE_STD, MODE_PS2, MODE_COMPAT_DATA_FIFO, MODE_ECP, MODE_TEST, MODE_CONFIG};
  logic [8:0] rv [4] = '{9'h102, 9'h077, 9'h185, 9'h011};
  logic [7:0] rx [4] = '{8'h77, 8'h77, 8'h77, 8'h11};

  always #25 clk_sys = ~clk_sys;
  // Contention shows as unknown on the lines
  assign lines = (d_oe && p_oe) ? 8'hxx : (d_oe ? d_out : p_drive);

  ppe_port #(.DEPTH(16)) dut_u (.clk_sys(clk_sys), .reset(reset), .cfg_base1_hi(8'h03), .cfg_base1_lo(8'h78),
    .cfg_base2_hi(8'h06), .cfg_base2_lo(base2_lo), .epp_enable(epp_enable), .io_addr(io_addr), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rd(io_rd), .io_rdata(io_rdata), .io_rdy(io_rdy), .parallel_data_lines_in(lines),
    .parallel_data_lines_out(d_out), .parallel_data_lines_oe(d_oe), .host_clock_out_n(stb_n),
    .host_ack_out_n(ack_out_n), .data_strobe_n(data_strobe_n_n), .reverse_request_out_n(init_n),
    .select_in_out_n(selin_n), .periph_flow_ack(busy), .periph_clock_in_n(pclk_n), .reverse_ack_n(pe_n),
    .select_in(select_in), .fault_in_n(fault_in_n), .periph_request(preq));

  ppe_periph #(.DLY(3)) per_u (.clk_sys(clk_sys), .host_clock_out_n(stb_n), .host_ack_out_n(ack_out_n),
    .data_strobe_n(data_strobe_n_n), .reverse_request_out_n(init_n), .select_in_out_n(selin_n), .bus_in(lines),
    .bus_drive(p_drive), .bus_oe(p_oe), .periph_flow_ack(busy), .periph_clock_in_n(pclk_n),
    .reverse_ack_n(pe_n), .rev_byte(rev_byte), .rev_cmd(rev_cmd), .rev_go(rev_go), .rev_busy(rev_busy),
    .fwd_byte(fwd_byte), .fwd_cmd(fwd_cmd), .fwd_count(fwd_count));

  task print_verdict;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk_sys);
    io_wr = 1'b0;
    @(negedge clk_sys);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    logic got;
    got = 1'b0;
    @(negedge clk_sys);
    io_addr = a;
    io_rd = 1'b1;
    for (int n = 0; n < 200 && !got; n++) begin
      @(negedge clk_sys);
      io_rd = 1'b0;
      if (io_rdy === 1'b1)
        got = 1'b1;
    end
    if (!got) begin
      err_total++;
      print_verdict();
    end
    chk(io_rdata, exp);
  endtask : rd

  task automatic wait_ev(input int kind, input int n);
    for (int i = 0; i < 500; i++) begin
      @(negedge clk_sys);
      if ((kind == 0 && fwd_count == n) || (kind == 1 && preq === 1'b1) || (kind == 2 && rev_busy === 1'b0))
        return;
    end
    err_total++;
    print_verdict();
  endtask : wait_ev

  // Data lines must be released while the enhanced strobe is low
  always @(negedge clk_sys) begin
    if (!reset && data_strobe_n_n === 1'b0) begin
      chk(d_oe, 1'b0);
      chk(ack_out_n, 1'b0);
    end
  end

  initial begin
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    rd(B1, 8'h00);
    rd(B1 + 16'h2, 8'hc0);
    rd(B2 + 16'h2, 8'h05);
    wr(B1, 8'ha5);
    chk({d_oe, d_out}, 16'h01a5);
    rd(B1, 8'ha5);
    rd(B2 + 16'h3, 8'hff);
    // Move window two up by four and back
    base2_lo = 8'hf4;
    rd(B2 + 16'h6, 8'h05);
    rd(B2 + 16'h2, 8'hff);
    base2_lo = 8'hf0;
    wr(B1 + 16'h1, 8'h00);
    select_in = 1'b1;
    rd(B1 + 16'h1, 8'hdf);
    epp_enable = 1'b1;
    rev_byte = 8'h3c;
    rd(B1 + 16'h4, 8'h3c);
    chk(data_strobe_n_n, 1'b1);
    repeat (6) @(negedge clk_sys);
    epp_enable = 1'b0;
    for (int i = 0; i < 6; i++) begin
      wr(B2 + 16'h2, {modes[i], 5'h04});
      rd(B2 + 16'h2, {modes[i], 5'h05});
    end
    rd(B2, 8'h10);
    wr(B2 + 16'h2, 8'h44);
    wr(B1, 8'hee);
    wr(B2, 8'h5a);
    wait_ev(0, 1);
    chk(fwd_byte, 8'h5a);
    wr(B2 + 16'h2, 8'h04);
    rd(B1, 8'ha5);
    wr(B1 + 16'h2, 8'h0c);
    chk(selin_n, 1'b0);
    wr(B2 + 16'h2, 8'h64);
    chk(selin_n, 1'b1);
    wr(B1, 8'h12);
    wait_ev(0, 2);
    chk({fwd_cmd, fwd_byte}, 16'h0112);
    wr(B2, 8'h34);
    wait_ev(0, 3);
    chk({fwd_cmd, fwd_byte}, 16'h0034);
    fault_in_n = 1'b0;
    wait_ev(1, 0);
    chk(preq, 1'b1);
    fault_in_n = 1'b1;
    wr(B2 + 16'h2, 8'hc4);
    for (int i = 0; i < 17; i++)
      wr(B2, 8'h40 + i[7:0]);
    rd(B2 + 16'h2, 8'hc6);
    for (int i = 0; i < 17; i++)
      rd(B2, 8'h40 + ((i < 16) ? i[7:0] : 8'h0f));
    rd(B2 + 16'h2, 8'hc5);
    wr(B2 + 16'h2, 8'h64);
    wr(B1 + 16'h2, 8'h20);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys);
      rev_cmd = rv[i][8];
      rev_byte = rv[i][7:0];
      rev_go = 1'b1;
      @(negedge clk_sys);
      rev_go = 1'b0;
      wait_ev(2, 0);
    end
    for (int i = 0; i < 4; i++)
      rd(B2, rx[i]);
    rd(B2 + 16'h2, 8'h65);
    chk(d_oe, 1'b0);
    rd(B1 + 16'h1, 8'hdf);
    // Bidirectional mode, input direction: released lines show inverse of last reverse byte
    wr(B2 + 16'h2, 8'h24);
    rd(B1, 8'hee);
    print_verdict();
  end
endmodule : ppe_port_tb
